// ===== rtl/drs_axil_slave.sv
// AXI4-Lite slave for the reset sequencer registers
`default_nettype none
module drs_axil_slave
  import drs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] causeWord,
  input wire logic [31:0] statWord,
  input wire logic [31:0] ctrlWord,
  output logic ctrlWe,
  output logic [31:0] ctrlWdata,
  output logic [3:0] ctrlWstrb
);
  logic [31:0] awAddr_q;
  logic awHave_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHave_q;
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  wire wrHit = (awAddr_q == RSEQ_CTRL_ADDR);
  wire wrRo = (awAddr_q == RESET_CAUSE_ADDR) || (awAddr_q == RSEQ_STAT_ADDR);
  wire rdCause = (s_axi_araddr == RESET_CAUSE_ADDR);
  wire rdCtrl = (s_axi_araddr == RSEQ_CTRL_ADDR);
  wire rdStat = (s_axi_araddr == RSEQ_STAT_ADDR);
  wire rdOk = rdCause || rdCtrl || rdStat;
  wire [31:0] rdMux = rdCause ? causeWord : rdCtrl ? ctrlWord : rdStat ? statWord : 32'h0000_0000;
  wire doRead = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !awHave_q;
  assign s_axi_wready = !wHave_q;
  assign s_axi_arready = !s_axi_rvalid;
  // Write path: capture address and data in any order, answer after both
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awAddr_q <= 32'h0000_0000;
      awHave_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      wHave_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrlWe <= 1'b0;
      ctrlWdata <= 32'h0000_0000;
      ctrlWstrb <= 4'h0;
    end else begin
      ctrlWe <= 1'b0;
      if (s_axi_awvalid && !awHave_q) begin
        awAddr_q <= s_axi_awaddr;
        awHave_q <= 1'b1;
      end
      if (s_axi_wvalid && !wHave_q) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHave_q <= 1'b1;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrHit || wrRo) ? 2'h0 : 2'h2;
        ctrlWe <= wrHit;
        ctrlWdata <= wData_q;
        ctrlWstrb <= wStrb_q;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Read path: one-cycle answer, DECERR on unmapped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? 2'h0 : 2'h3;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // drs_axil_slave
`default_nettype wire

// ===== rtl/drs_reset_seq.sv
// Device reset sequencer top: reset priority, sequencing, pin control
// Operation
// - Warm reset spares emulation logic only
// - Warm/max reset forces multipliers to bypass
// - Reset-out low during any reset sequence
// - Warm release latches pins, starts init
// - Pause clocks ten cycles, then release
// - After release, default peripherals own pins
// - CPU boots from vector, still bypass
// - Max reset equals warm, no relatch
// - Emulator max reset is never masked
// - Watchdog expiry starts a max reset
// - Watchdog reset gated by enable bit
// - Max reset boots from latched config
// - CPU local reset from module control
// - CPU slave DMA stays up
// - Peripheral local resets individually controllable
// - Only highest priority reset is served
// - Single reset cause register at address
// - Boot pins tristated while reset-out low
// - Powered-down pins stay off until reprogrammed
// - Latch boot pins on AND rising
`default_nettype none
module drs_reset_seq
  import drs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic porPin_n,
  input wire logic warmPin_n,
  input wire logic emuMaxReq,
  input wire logic wdogExpire,
  input wire logic [BOOT_W-1:0] bootPinIn,
  output logic [BOOT_W-1:0] bootPinOe,
  output logic reset_out_n_n,
  output logic sysRst_n,
  output logic emuRst_n,
  output logic multBypass,
  output logic multRst,
  output logic multLockLost,
  output logic clkPause,
  output logic defaultDivide,
  output logic pinOwnDefault,
  output logic cpuBootGo,
  output logic [BOOT_W-1:0] bootConfig,
  output logic cpuRst_n,
  output logic cpuDmaEn,
  output logic [PERIPH_W-1:0] periphRst_n,
  output logic ioPowerDown,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic porS_n;
  logic warmS_n;
  logic emuS;
  logic wdogS;
  logic [BOOT_W-1:0] bootS;
  drs_sync2 #(.W(4), .INIT(4'h0)) u_syncCtl (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({porPin_n, warmPin_n, emuMaxReq, wdogExpire}),
    .syncOut({porS_n, warmS_n, emuS, wdogS})
  );
  drs_sync2 #(.W(BOOT_W), .INIT(BOOT_RST)) u_syncBoot (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(bootPinIn),
    .syncOut(bootS)
  );
  // ----------------------------------------
  // Registers and bus
  // ----------------------------------------
  drs_state_e state_q;
  drs_state_e state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [3:0] cause_q;
  logic wdEn_q;
  logic cpuLrst_q;
  logic ioPd_q;
  logic pselDone_q;
  logic [PERIPH_W-1:0] periph_q;
  logic andPrev_q;
  logic wdHold_q;
  logic ctrlWe;
  logic [31:0] ctrlWdata;
  logic [3:0] ctrlWstrb;
  wire [31:0] ctrlWord = {16'h0000, periph_q, 4'h0, pselDone_q, ioPd_q, cpuLrst_q, wdEn_q};
  wire [31:0] causeWord = {28'h000_0000, cause_q};
  wire [31:0] statWord = {29'h000_0000, 3'(state_q)};
  drs_axil_slave u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .causeWord(causeWord),
    .statWord(statWord),
    .ctrlWord(ctrlWord),
    .ctrlWe(ctrlWe),
    .ctrlWdata(ctrlWdata),
    .ctrlWstrb(ctrlWstrb)
  );
  // ----------------------------------------
  // Reset request arbitration
  // ----------------------------------------
  // Watchdog request gated by enable; an accepted one lasts while the line stays up
  // Emulator request has no mask
  wire wdReq = wdogS && (wdEn_q || wdHold_q);
  wire maxReq = emuS || wdReq;
  wire porReq = !porS_n;
  wire warmReq = !warmS_n;
  wire anyGlobal = porReq || maxReq || warmReq;
  // Highest source only: por > max > warm
  wire [3:0] causeNew = porReq ? 4'h1 : emuS ? 4'h4 : wdReq ? 4'h8 : 4'h2;
  wire andNow = porS_n && warmS_n;
  wire latchEdge = andNow && !andPrev_q;
  wire ctrlLo = ctrlWe && ctrlWstrb[0];
  wire ctrlB1 = ctrlWe && ctrlWstrb[1];
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      DRS_HOLD: begin
        if (!anyGlobal) begin
          state_d = DRS_INIT;
          cnt_d = INIT_LOAD;
        end
      end
      DRS_INIT: begin
        if (cnt_q == 5'h00) begin
          state_d = DRS_PAUSE;
          cnt_d = PAUSE_LOAD;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      DRS_PAUSE: begin
        if (cnt_q == 5'h00) begin
          state_d = DRS_RUN;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      DRS_RUN: begin
        state_d = DRS_RUN;
      end
      default: begin
        state_d = DRS_HOLD;
      end
    endcase
    if (anyGlobal) begin
      state_d = DRS_HOLD;
      cnt_d = 5'h00;
    end
  end
  // State, counter and accepted watchdog request
  // Enable falls to default in HOLD, so the hold keeps the max reset from being cut short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DRS_HOLD;
      cnt_q <= 5'h00;
      andPrev_q <= 1'b0;
      wdHold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      andPrev_q <= andNow;
      wdHold_q <= wdogS && (wdHold_q || wdEn_q);
    end
  end
  // Cause register, latest highest-priority source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= CAUSE_RST;
    end else if (anyGlobal) begin
      cause_q <= causeNew;
    end
  end
  // Boot config latch: only on AND rising, not on max reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bootConfig <= BOOT_RST;
    end else if (latchEdge) begin
      bootConfig <= bootS;
    end
  end
  // Control bits, return to defaults on any global reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdEn_q <= 1'b0;
      cpuLrst_q <= 1'b0;
      ioPd_q <= 1'b1;
      pselDone_q <= 1'b0;
      periph_q <= PERIPH_RST;
    end else if (state_q != DRS_RUN) begin
      wdEn_q <= 1'b0;
      cpuLrst_q <= 1'b0;
      ioPd_q <= 1'b1;
      pselDone_q <= 1'b0;
      periph_q <= PERIPH_RST;
    end else begin
      if (ctrlLo) begin
        wdEn_q <= ctrlWdata[CTRL_WDEN_BIT];
        cpuLrst_q <= ctrlWdata[CTRL_CPURST_BIT];
        ioPd_q <= ctrlWdata[CTRL_IOPD_BIT];
        pselDone_q <= ctrlWdata[CTRL_PSEL_BIT];
      end
      if (ctrlB1) begin
        periph_q <= ctrlWdata[CTRL_PERIPH_LSB +: PERIPH_W];
      end
    end
  end
  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  wire inRun = (state_d == DRS_RUN);
  wire inReset = (state_d == DRS_HOLD);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_out_n_n <= 1'b0;
      sysRst_n <= 1'b0;
      emuRst_n <= 1'b0;
      multBypass <= 1'b1;
      multRst <= 1'b1;
      multLockLost <= 1'b1;
      clkPause <= 1'b0;
      defaultDivide <= 1'b0;
      pinOwnDefault <= 1'b0;
      cpuBootGo <= 1'b0;
      bootPinOe <= '0;
      cpuRst_n <= 1'b0;
      cpuDmaEn <= 1'b0;
      periphRst_n <= '0;
      ioPowerDown <= 1'b1;
    end else begin
      reset_out_n_n <= inRun;
      sysRst_n <= !inReset;
      emuRst_n <= porS_n;
      multBypass <= 1'b1;
      multRst <= inReset;
      multLockLost <= inReset;
      clkPause <= (state_d == DRS_PAUSE);
      defaultDivide <= !inReset;
      pinOwnDefault <= inRun;
      cpuBootGo <= inRun;
      bootPinOe <= inRun ? {BOOT_W{1'b1}} : {BOOT_W{1'b0}};
      cpuRst_n <= inRun && !cpuLrst_q;
      cpuDmaEn <= inRun;
      periphRst_n <= inRun ? ~periph_q : {PERIPH_W{1'b0}};
      ioPowerDown <= ioPd_q || !pselDone_q || !inRun;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_pauseTen;
    clkPause [*8] ##1 clkPause ##1 clkPause;
  endsequence
  a_pause_len: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(clkPause) |-> s_pauseTen ##1 (!clkPause && reset_out_n_n))
    else $error("pause not ten cycles before release");
  a_out_low: assert property (@(posedge clk) disable iff (!rst_n)
    (anyGlobal) |=> !reset_out_n_n)
    else $error("reset-out high during reset");
  a_emu_honor: assert property (@(posedge clk) disable iff (!rst_n)
    emuS |=> (state_q == DRS_HOLD) && cause_q == 4'h4 || porReq)
    else $error("emulator reset not taken");
  a_wd_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (wdogS && !wdEn_q && !porReq && !warmReq && !emuS && state_q == DRS_RUN) |=> state_q == DRS_RUN)
    else $error("masked watchdog caused reset");
  a_max_nolatch: assert property (@(posedge clk) disable iff (!rst_n)
    (porS_n && warmS_n && andPrev_q) |=> $stable(bootConfig))
    else $error("config relatched without pin edge");
  a_por_prio: assert property (@(posedge clk) disable iff (!rst_n)
    porReq |=> cause_q == 4'h1)
    else $error("power-on not top priority");
  a_boot_z: assert property (@(posedge clk) disable iff (!rst_n)
    !reset_out_n_n |-> bootPinOe == '0)
    else $error("boot pins driven in reset");
  a_mult_byp: assert property (@(posedge clk) disable iff (!rst_n)
    anyGlobal |=> multRst && multLockLost && multBypass)
    else $error("multiplier not held in reset");
  a_cpu_local_reset_bit: assert property (@(posedge clk) disable iff (!rst_n)
    cpuLrst_q |=> !cpuRst_n)
    else $error("cpu not held by local reset");
  a_dma_live: assert property (@(posedge clk) disable iff (!rst_n)
    (reset_out_n_n && !cpuRst_n) |-> cpuDmaEn)
    else $error("dma port off in cpu reset");
  // Emulation logic survives a warm reset
  a_emu_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (warmReq && porS_n) |=> emuRst_n && !sysRst_n)
    else $error("emulation reset by warm reset");
  // Watchdog cause recorded when it is the top request
  a_wd_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (wdReq && !porReq && !emuS) |=> cause_q == 4'h8)
    else $error("watchdog cause not recorded");
  // Leaving HOLD switches to default divide, reset-out still low
  a_div_init: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == DRS_HOLD && !anyGlobal) |=> defaultDivide && !reset_out_n_n)
    else $error("default divide not applied on release");
  // Release hands pins to defaults and starts the CPU in bypass
  a_rel_flags: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(reset_out_n_n) |-> pinOwnDefault && cpuBootGo && multBypass)
    else $error("release flags missing");
  // Running state keeps reset-out high
  a_run_high: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == DRS_RUN && !anyGlobal) |=> reset_out_n_n)
    else $error("reset-out low while running");
  // Powered-down pins stay off through reset
  a_pd_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !reset_out_n_n |-> ioPowerDown)
    else $error("pins powered during reset");
  // Warm request keeps the multipliers in reset
  a_warm_mult: assert property (@(posedge clk) disable iff (!rst_n)
    warmReq |=> multRst && multLockLost)
    else $error("multiplier left running in warm reset");
endmodule // drs_reset_seq
`default_nettype wire

// ===== rtl/drs_sync2.sv
// Two-flop synchroniser for asynchronous pin levels
`default_nettype none
module drs_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_q;
  // ----------------------------------------
  // Two stages
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      syncOut <= INIT;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // drs_sync2
`default_nettype wire

// ===== shared/drs_pkg.sv
// Package with constants and types for the device reset sequencer
`default_nettype none
package drs_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] RESET_CAUSE_ADDR = 32'h01c4_00e4;
  localparam logic [31:0] RSEQ_CTRL_ADDR = 32'h01c4_00e8;
  localparam logic [31:0] RSEQ_STAT_ADDR = 32'h01c4_00ec;
  // reset_cause field positions
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_WARM_BIT = 1;
  localparam int CAUSE_EMU_BIT = 2;
  localparam int CAUSE_WDOG_BIT = 3;
  // Control register field positions
  localparam int CTRL_WDEN_BIT = 0;
  localparam int CTRL_CPURST_BIT = 1;
  localparam int CTRL_IOPD_BIT = 2;
  localparam int CTRL_PSEL_BIT = 3;
  localparam int CTRL_PERIPH_LSB = 8;
  // ----------------------------------------
  // Reset values and widths
  // ----------------------------------------
  localparam logic [3:0] CAUSE_RST = 4'h1;
  localparam int PERIPH_W = 8;
  localparam logic [PERIPH_W-1:0] PERIPH_RST = 8'h00;
  localparam int BOOT_W = 13;
  localparam logic [BOOT_W-1:0] BOOT_RST = 13'h0000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PIN_LOW_MIN_CYC = 12;
  localparam int PAUSE_CYC = 10;
  localparam int INIT_CYC = 16;
  localparam logic [4:0] PAUSE_LOAD = 5'(PAUSE_CYC - 1);
  localparam logic [4:0] INIT_LOAD = 5'(INIT_CYC - 1);
  // Sequencer states
  typedef enum logic [2:0] {
    DRS_HOLD, DRS_INIT, DRS_PAUSE, DRS_RUN
  } drs_state_e;
endpackage
`default_nettype wire

// ===== testbench/device_reset_sequencer_tb.sv
// Self-checking bench for the device reset sequencer
`default_nettype none
module device_reset_sequencer_tb;
  import drs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic porPin_n, warmPin_n, emuMaxReq, wdogExpire;
  logic [BOOT_W-1:0] bootPinIn, bootPinOe, bootConfig;
  logic reset_out_n_n, sysRst_n, emuRst_n, multBypass, multRst, multLockLost, clkPause;
  logic defaultDivide, pinOwnDefault, cpuBootGo, cpuRst_n, cpuDmaEn, ioPowerDown;
  logic [PERIPH_W-1:0] periphRst_n;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0, checkCount = 0, lowCnt = 0, expCause;
  logic [BOOT_W-1:0] expBoot;
  logic [31:0] seed;
  logic [3:0] srcQ[$] = '{4'b0010, 4'b0100, 4'b0001, 4'b0110, 4'b0011};

  always #5 clk = ~clk;

  // Count cycles with reset-out low
  always @(posedge clk) if (reset_out_n_n === 1'b0) lowCnt <= lowCnt + 1;

  drs_reset_partner farSide (.clk, .porPin_n, .warmPin_n, .emuMaxReq, .wdogExpire, .bootPinIn);

  drs_reset_seq uut (.clk, .rst_n, .porPin_n, .warmPin_n, .emuMaxReq, .wdogExpire, .bootPinIn, .bootPinOe,
    .reset_out_n_n, .sysRst_n, .emuRst_n, .multBypass, .multRst, .multLockLost, .clkPause, .defaultDivide,
    .pinOwnDefault, .cpuBootGo, .bootConfig, .cpuRst_n, .cpuDmaEn, .periphRst_n, .ioPowerDown,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic endOfTest();
    $display("Checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Write one word and check the response code
  task automatic axiWrite(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] expResp);
    @(posedge clk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chkVal("bresp", 32'(expResp), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
  endtask

  // Read one word and check data and response code
  task automatic axiRead(input logic [31:0] addr, input logic [31:0] expData, input logic [1:0] expResp);
    @(posedge clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chkVal("rdata", expData, s_axi_rdata);
    chkVal("rresp", 32'(expResp), 32'(s_axi_rresp));
    s_axi_rready <= 1'b0;
  endtask

  // Wait for release, count the clock pause, then check the running state
  task automatic waitRun();
    int pause;
    int t;
    pause = 0;
    for (t = 0; t < 400 && reset_out_n_n !== 1'b1; t++) begin
      @(posedge clk);
      if (clkPause === 1'b1) pause++;
    end
    chkVal("pauseCycles", PAUSE_CYC, pause);
    chkVal("pauseAtRelease", 0, 32'(clkPause));
    @(posedge clk);
    chkVal("bootOe", 32'h0000_1fff, 32'(bootPinOe));
    chkVal("runFlags", 32'h0000_001f, 32'({pinOwnDefault, cpuBootGo, multBypass, defaultDivide, sysRst_n}));
    chkVal("runMult", 0, 32'({multRst, multLockLost}));
    chkVal("boot_config_latch", 32'(expBoot), 32'(bootConfig));
    chkVal("runLocal", 32'h0000_07ff, 32'({cpuRst_n, cpuDmaEn, ioPowerDown, periphRst_n}));
    axiRead(RESET_CAUSE_ADDR, 32'(expCause), 2'b00);
    axiRead(RSEQ_CTRL_ADDR, 32'h0000_0004, 2'b00);
    axiRead(RSEQ_STAT_ADDR, 32'h0000_0003, 2'b00);
  endtask

  // Run one reset request from the far side and check inside and after it
  task automatic fire(input logic [3:0] src, input logic [BOOT_W-1:0] boot);
    if (src[0]) expCause = 1 << CAUSE_POR_BIT;
    else if (src[2]) expCause = 1 << CAUSE_EMU_BIT;
    else if (src[3]) expCause = 1 << CAUSE_WDOG_BIT;
    else expCause = 1 << CAUSE_WARM_BIT;
    if (src[0] || src[1]) expBoot = boot;
    fork
      farSide.pulse(src, 20, boot);
      begin
        repeat (10) @(posedge clk);
        chkVal("inReset", 32'({4'b0011, 1'b1, !src[0], 1'b0}),
          32'({reset_out_n_n, sysRst_n, multRst, multLockLost, multBypass, emuRst_n, cpuBootGo}));
        chkVal("resetOe", 0, 32'(bootPinOe));
      end
    join
    waitRun();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] per;
    int lows;
    seed = 32'h9695_b187;
    expCause = 1 << CAUSE_POR_BIT;
    expBoot = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    waitRun();
    // Refused and ignored accesses
    axiWrite(32'h01c4_00f0, 32'h0000_ffff, 2'b10);
    axiRead(32'h01c4_00f0, 32'h0000_0000, 2'b11);
    axiWrite(RESET_CAUSE_ADDR, 32'h0000_000f, 2'b00);
    axiRead(RESET_CAUSE_ADDR, 32'(expCause), 2'b00);
    // Peripheral local resets and pin power
    per = 8'(rnd());
    axiWrite(RSEQ_CTRL_ADDR, {16'h0000, per, 8'h08}, 2'b00);
    repeat (2) @(posedge clk);
    chkVal("periphRst", {24'h00_0000, ~per}, 32'(periphRst_n));
    chkVal("ioPowerDown", 0, 32'(ioPowerDown));
    axiRead(RSEQ_CTRL_ADDR, {16'h0000, per, 8'h08}, 2'b00);
    // CPU local reset with DMA port kept alive
    axiWrite(RSEQ_CTRL_ADDR, {16'h0000, per, 8'h0a}, 2'b00);
    repeat (2) @(posedge clk);
    chkVal("cpuLocal", 32'h0000_0001, 32'({cpuRst_n, cpuDmaEn}));
    // Watchdog expiry while its reset is disabled
    lows = lowCnt;
    farSide.pulse(4'b1000, 12, bootPinIn);
    repeat (8) @(posedge clk);
    chkVal("wdogMasked", 0, lowCnt - lows);
    // Watchdog expiry with its reset enabled
    axiWrite(RSEQ_CTRL_ADDR, 32'h0000_0005, 2'b00);
    fire(4'b1000, BOOT_W'(rnd()));
    // Warm, emulator and power-on sources alone, then two coinciding pairs
    foreach (srcQ[i]) fire(srcQ[i], BOOT_W'(rnd()));
    endOfTest();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    endOfTest();
  end
endmodule // device_reset_sequencer_tb
`default_nettype wire

// ===== testbench/drs_reset_partner.sv
// Far-side model: external reset source, emulator and watchdog
`default_nettype none
module drs_reset_partner
  import drs_pkg::*;
(
  input wire logic clk,
  output var logic porPin_n,
  output var logic warmPin_n,
  output var logic emuMaxReq,
  output var logic wdogExpire,
  output var logic [BOOT_W-1:0] bootPinIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels: reset pins high, no requests
  initial begin
    porPin_n = 1'b1;
    warmPin_n = 1'b1;
    emuMaxReq = 1'b0;
    wdogExpire = 1'b0;
    bootPinIn = '0;
  end

  // Assert the chosen sources (bit0 por, 1 warm, 2 emulator, 3 watchdog), hold, release
  task automatic pulse(input logic [3:0] src, input int len, input logic [BOOT_W-1:0] boot);
    int n;
    n = (len < PIN_LOW_MIN_CYC) ? PIN_LOW_MIN_CYC : len;
    @(posedge clk);
    bootPinIn <= boot;
    porPin_n <= !src[0];
    warmPin_n <= !src[1];
    emuMaxReq <= src[2];
    wdogExpire <= src[3];
    repeat (n) @(posedge clk);
    porPin_n <= 1'b1;
    warmPin_n <= 1'b1;
    emuMaxReq <= 1'b0;
    wdogExpire <= 1'b0;
    // Boot pins wander once the hold time is over, so a late capture shows
    repeat (2) @(posedge clk);
    bootPinIn <= ~boot;
  endtask
endmodule // drs_reset_partner
`default_nettype wire
